// *** hw/inr_regs.svh ***
// Register offsets, field positions, reset values and scaling for the inrush detector.
// Assumes byte addresses on a 32-bit Avalon-MM slave, one register per aligned word.
`ifndef INR_REGS_SVH
`define INR_REGS_SVH

`define INR_OFS_CTRL      5'h00
`define INR_OFS_RATIO     5'h04
`define INR_OFS_MINLVL    5'h08
`define INR_OFS_FLAGS     5'h0c
`define INR_OFS_IRQ_STAT  5'h10
`define INR_OFS_IRQ_MASK  5'h14

`define INR_CTRL_EN_BIT   0
`define INR_FLAGS_GEN_BIT 3
`define INR_IRQ_ON_BIT    0
`define INR_IRQ_OFF_BIT   1

`define INR_CTRL_EN_RST   1'h0
`define INR_RATIO_RST     7'h0f
`define INR_RATIO_MIN     7'h05
`define INR_RATIO_MAX     7'h32
`define INR_MINLVL_RST    7'h1e
`define INR_MINLVL_MIN    7'h14
`define INR_MINLVL_MAX    7'h64
`define INR_IRQ_MASK_RST  2'h0

// Percent scale and the magnitude code that equals the nominal CT current
`define INR_PCT_FULL      7'h64
`define INR_NOMINAL_CODE  16'h1000

`endif

// *** hw/inr_pkg.sv ***
// Types shared by the inrush detector modules.
// Assumes magnitudes are unsigned 16-bit codes from the measurement stage.
package inr_pkg;

   typedef logic [15:0] inr_mag_t;
   typedef logic [6:0]  inr_pct_t;
   typedef logic [23:0] inr_prod_t;

   typedef struct packed {
      logic                valid;
      inr_mag_t [2:0]      fund;
      inr_mag_t [2:0]      harm;
   } inr_sample_s;

   typedef struct packed {
      logic [1:0]          status;
      logic                irq;
   } inr_irq_s;

   typedef struct packed {
      logic                wait_n;
      logic [31:0]         rdata;
      logic                enable;
      inr_pct_t            ratio;
      inr_pct_t            minlvl;
      logic [2:0]          phase;
      logic                general;
      logic                evt_valid;
      logic                evt_value;
      logic [1:0]          mask;
   } inr_state_s;

endpackage : inr_pkg

// *** hw/inr_phase_cmp.sv ***
// One phase of the inrush comparison, purely combinational.
// Assumes settings are already within range; the caller registers the result.
module inr_phase_cmp (
   input  wire inr_pkg::inr_mag_t fund,      // Fundamental magnitude
   input  wire inr_pkg::inr_mag_t harm,      // Second-harmonic magnitude
   input  wire inr_pkg::inr_pct_t ratio,     // Harmonic ratio, percent
   input  wire inr_pkg::inr_pct_t minlvl,    // Minimum fundamental, percent of nominal
   output logic                   detect     // Inrush seen on this phase
);
   import inr_pkg::*;
`include "inr_regs.svh"

   inr_prod_t harm_scaled;
   inr_prod_t fund_scaled;
   inr_prod_t fund_pct;
   inr_prod_t level_ref;

   always_comb begin
      // Cross-multiplied so no divider is needed
      harm_scaled = inr_prod_t'(harm) * inr_prod_t'(`INR_PCT_FULL);   // see RULE12
      fund_scaled = inr_prod_t'(fund) * inr_prod_t'(ratio);
      fund_pct    = inr_prod_t'(fund) * inr_prod_t'(`INR_PCT_FULL);
      level_ref   = inr_prod_t'(minlvl) * inr_prod_t'(`INR_NOMINAL_CODE);   // see RULE8
      detect      = (harm_scaled > fund_scaled) && (fund_pct > level_ref);   // see RULE1 // see RULE2
   end

endmodule : inr_phase_cmp

// *** hw/inr_irq.sv ***
// Sticky event status, mask and level interrupt.
// Assumes clr_rd pulses for the one cycle in which software's status read completes.
module inr_irq (
   input  wire logic       mclk,     // System clock
   input  wire logic       rstn,     // Asynchronous reset, active low
   input  wire logic [1:0] set,      // Event pulses
   input  wire logic       clr_rd,   // Status read completes
   input  wire logic [1:0] mask,     // Enabled events
   output logic      [1:0] status,   // Sticky status
   output logic            irq       // Interrupt level
);
   import inr_pkg::*;

   inr_irq_s st_q;
   inr_irq_s st_d;

   always_comb begin
      st_d = st_q;
      // A set in the clearing cycle survives the clear
      st_d.status = (clr_rd ? 2'h0 : st_q.status) | set;
      st_d.irq    = |(st_d.status & mask);
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign status = st_q.status;
   assign irq    = st_q.irq;

endmodule : inr_irq

// *** hw/inr_detector.sv ***
// Second-harmonic inrush detector: three phase comparators, flags, events, registers.
// Assumes one clock, magnitudes synchronous to mclk with a one-cycle valid strobe,
// and an Avalon-MM master that holds its request until waitrequest is seen low.
//
// Behaviour
// RULE1: A phase flags inrush when second harmonic over fundamental exceeds the ratio setting.
// RULE2: A phase flag needs its fundamental above the minimum level setting.
// RULE3: Phases L1, L2, L3 are judged separately, each with its own flag.
// RULE4: The general flag is high when any phase flag is high.
// RULE5: A high block input forces every flag low.
// RULE6: Ratio setting takes 5 to 50 percent in whole steps, resets to 15.
// RULE7: Minimum level takes 20 to 100 percent in whole steps, resets to 30.
// RULE8: Minimum level is a percentage of nominal CT current, checked per phase.
// RULE9: The measurement stage supplies fundamental and second-harmonic magnitudes per phase.
// RULE10: General flag rising emits an on event, falling emits an off event. A fall caused by writing enable off emits no event.
// RULE11: An enable setting, off after reset, gates all flags and events.
// RULE12: Comparison by cross-multiplication, flags updated once per input sample.
//
// The implementer's own choices: the Avalon-MM slave port and the placing of the registers.
module inr_detector (
   input  wire logic               mclk,                  // System sample clock
   input  wire logic               rstn,                  // Asynchronous reset, active low
   input  wire logic [4:0]         avs_address,           // Byte address
   input  wire logic               avs_read,              // Read request
   input  wire logic               avs_write,             // Write request
   input  wire logic [31:0]        avs_writedata,         // Write data
   output logic      [31:0]        avs_readdata,          // Read data
   output logic                    avs_waitrequest,       // Request not yet taken
   input  wire inr_pkg::inr_sample_s sample,              // Per-phase magnitudes with strobe
   input  wire logic               detector_block_input,  // Disable from user logic
   output logic                    phase1_inrush_flag,    // Inrush on L1
   output logic                    phase2_inrush_flag,    // Inrush on L2
   output logic                    phase3_inrush_flag,    // Inrush on L3
   output logic                    general_inrush_flag,   // Inrush on any phase
   output logic                    restraint_event_valid, // Event pulse
   output logic                    restraint_event_value, // Event value, 1 on, 0 off
   output logic                    irq                    // Interrupt level
);
   import inr_pkg::*;
`include "inr_regs.svh"

   inr_state_s st_q;
   inr_state_s st_d;

   logic [2:0] det_c;
   logic [1:0] irq_status;
   logic [1:0] irq_set;
   logic       req;
   logic       take;
   logic       wr_take;
   logic       rd_take;
   logic       gate_on;
   logic       stat_rd;

   // One comparator per phase, fed from the matching slice of the sample
   genvar gi;
   generate
      for (gi = 0; gi < 3; gi++) begin : g_phase
         inr_phase_cmp u_cmp (                                  // see RULE3 // see RULE9
            .fund   (sample.fund[gi]),
            .harm   (sample.harm[gi]),
            .ratio  (st_q.ratio),
            .minlvl (st_q.minlvl),
            .detect (det_c[gi])
         );
      end
   endgenerate

   always_comb begin
      req     = avs_read || avs_write;
      take    = req && st_q.wait_n;
      wr_take = avs_write && st_q.wait_n;
      rd_take = avs_read && st_q.wait_n;
      stat_rd = rd_take && (avs_address == `INR_OFS_IRQ_STAT);
      // Enable written off acts at the write edge, so no flag can rise without its event
      gate_on = st_q.enable && !(wr_take && (avs_address == `INR_OFS_CTRL) &&
                                 !avs_writedata[`INR_CTRL_EN_BIT]) && !detector_block_input;
   end

   always_comb begin
      st_d           = st_q;
      st_d.evt_valid = 1'b0;
      st_d.evt_value = st_q.evt_value;

      // Waitrequest drops for exactly one cycle per request; the request is taken there
      st_d.wait_n = req && !st_q.wait_n;

      // Read data is prepared one cycle ahead so it stands when waitrequest is low
      // Status includes pending sets, as the clear at the taking edge would lose them
      st_d.rdata = 32'h0;
      if (req && !st_q.wait_n) begin
         unique case (avs_address)
            `INR_OFS_CTRL:     st_d.rdata[`INR_CTRL_EN_BIT] = st_q.enable;
            `INR_OFS_RATIO:    st_d.rdata[6:0] = st_q.ratio;
            `INR_OFS_MINLVL:   st_d.rdata[6:0] = st_q.minlvl;
            `INR_OFS_FLAGS:    st_d.rdata[3:0] = {st_q.general, st_q.phase};
            `INR_OFS_IRQ_STAT: st_d.rdata[1:0] = irq_status | irq_set;
            `INR_OFS_IRQ_MASK: st_d.rdata[1:0] = st_q.mask;
            default:           st_d.rdata = 32'h0;
         endcase
      end

      if (wr_take) begin
         unique case (avs_address)
            `INR_OFS_CTRL: begin
               st_d.enable = avs_writedata[`INR_CTRL_EN_BIT];   // see RULE11
            end
            `INR_OFS_RATIO: begin
               // Values outside the setting range are ignored, not clamped
               if (avs_writedata[31:0] >= 32'(`INR_RATIO_MIN) &&
                   avs_writedata[31:0] <= 32'(`INR_RATIO_MAX)) begin   // see RULE6
                  st_d.ratio = avs_writedata[6:0];
               end
            end
            `INR_OFS_MINLVL: begin
               if (avs_writedata[31:0] >= 32'(`INR_MINLVL_MIN) &&
                   avs_writedata[31:0] <= 32'(`INR_MINLVL_MAX)) begin   // see RULE7
                  st_d.minlvl = avs_writedata[6:0];
               end
            end
            `INR_OFS_IRQ_MASK: begin
               st_d.mask = avs_writedata[1:0];
            end
            default: begin
               st_d.mask = st_q.mask;
            end
         endcase
      end

      // Block and disable act at once; a new sample is needed to raise a flag again
      if (!gate_on) begin
         st_d.phase   = 3'h0;                                   // see RULE5 // see RULE11
         st_d.general = 1'b0;
      end else if (sample.valid) begin
         st_d.phase   = det_c;                                  // see RULE12
         st_d.general = |det_c;                                 // see RULE4
      end

      // Disabling drops the flags silently; a block still reports the fall
      if (st_q.enable && st_d.enable && (st_d.general != st_q.general)) begin
         st_d.evt_valid = 1'b1;                                 // see RULE10
         st_d.evt_value = st_d.general;
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         st_q           <= '0;
         st_q.enable    <= `INR_CTRL_EN_RST;
         st_q.ratio     <= `INR_RATIO_RST;
         st_q.minlvl    <= `INR_MINLVL_RST;
         st_q.mask      <= `INR_IRQ_MASK_RST;
      end else begin
         st_q <= st_d;
      end
   end

   always_comb begin
      irq_set                   = 2'h0;
      irq_set[`INR_IRQ_ON_BIT]  = st_q.evt_valid && st_q.evt_value;
      irq_set[`INR_IRQ_OFF_BIT] = st_q.evt_valid && !st_q.evt_value;
   end

   inr_irq u_irq (
      .mclk   (mclk),
      .rstn   (rstn),
      .set    (irq_set),
      .clr_rd (stat_rd),
      .mask   (st_q.mask),
      .status (irq_status),
      .irq    (irq)
   );

   assign avs_readdata          = st_q.rdata;
   assign avs_waitrequest       = !st_q.wait_n;
   assign phase1_inrush_flag    = st_q.phase[0];
   assign phase2_inrush_flag    = st_q.phase[1];
   assign phase3_inrush_flag    = st_q.phase[2];
   assign general_inrush_flag   = st_q.general;
   assign restraint_event_valid = st_q.evt_valid;
   assign restraint_event_value = st_q.evt_value;

   // Checks
   inr_prod_t chk_harm1;
   inr_prod_t chk_fund1;
   inr_prod_t chk_lvl2;
   inr_prod_t chk_ref2;
   inr_prod_t chk_harm2;
   inr_prod_t chk_fund2;
   inr_prod_t chk_harm3;
   inr_prod_t chk_fund3;
   inr_prod_t chk_lvl1;
   inr_prod_t chk_lvl3;

   always_comb begin
      chk_harm1 = inr_prod_t'(sample.harm[0]) * inr_prod_t'(`INR_PCT_FULL);
      chk_fund1 = inr_prod_t'(sample.fund[0]) * inr_prod_t'(st_q.ratio);
      chk_lvl2  = inr_prod_t'(sample.fund[1]) * inr_prod_t'(`INR_PCT_FULL);
      chk_ref2  = inr_prod_t'(st_q.minlvl) * inr_prod_t'(`INR_NOMINAL_CODE);
      chk_harm2 = inr_prod_t'(sample.harm[1]) * inr_prod_t'(`INR_PCT_FULL);
      chk_fund2 = inr_prod_t'(sample.fund[1]) * inr_prod_t'(st_q.ratio);
      chk_harm3 = inr_prod_t'(sample.harm[2]) * inr_prod_t'(`INR_PCT_FULL);
      chk_fund3 = inr_prod_t'(sample.fund[2]) * inr_prod_t'(st_q.ratio);
      chk_lvl1  = inr_prod_t'(sample.fund[0]) * inr_prod_t'(`INR_PCT_FULL);
      chk_lvl3  = inr_prod_t'(sample.fund[2]) * inr_prod_t'(`INR_PCT_FULL);
   end

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rstn);

   ratio_flag_a: assert property (                              // see RULE1
      (gate_on && st_q.enable && sample.valid && (chk_harm1 <= chk_fund1))
      |=> !phase1_inrush_flag)
      else $error("phase 1 flag set without harmonic ratio exceeded");

   min_level_a: assert property (                               // see RULE2
      (gate_on && sample.valid && (chk_lvl2 <= chk_ref2)) |=> !phase2_inrush_flag)
      else $error("phase 2 flag set with fundamental below minimum level");

   phase_indep_a: assert property (                             // see RULE3
      (gate_on && sample.valid) |=> ({phase3_inrush_flag, phase2_inrush_flag,
                                      phase1_inrush_flag} == $past(det_c)))
      else $error("phase flags do not follow their own comparators");

   general_or_a: assert property (                              // see RULE4
      general_inrush_flag == (phase1_inrush_flag || phase2_inrush_flag || phase3_inrush_flag))
      else $error("general flag differs from OR of phase flags");

   block_clear_a: assert property (                             // see RULE5
      detector_block_input |=> !general_inrush_flag && !phase1_inrush_flag &&
                               !phase2_inrush_flag && !phase3_inrush_flag)
      else $error("flags not cleared while blocked");

   ratio_range_a: assert property (                             // see RULE6
      (st_q.ratio >= `INR_RATIO_MIN) && (st_q.ratio <= `INR_RATIO_MAX))
      else $error("harmonic ratio setting out of range");

   minlvl_range_a: assert property (                            // see RULE7
      (st_q.minlvl >= `INR_MINLVL_MIN) && (st_q.minlvl <= `INR_MINLVL_MAX))
      else $error("minimum level setting out of range");

   event_rise_a: assert property (                              // see RULE10
      ($rose(general_inrush_flag) && $past(st_q.enable)) |-> restraint_event_valid &&
                                                           restraint_event_value)
      else $error("no on event at general flag rise");

   event_fall_a: assert property (                              // see RULE10
      ($fell(general_inrush_flag) && st_q.enable && $past(st_q.enable))
      |-> restraint_event_valid && !restraint_event_value)
      else $error("no off event at general flag fall");

   disabled_quiet_a: assert property (                          // see RULE11
      (!st_q.enable ##1 !st_q.enable) |-> !general_inrush_flag && !restraint_event_valid)
      else $error("activity while detector disabled");

   sample_hold_a: assert property (                             // see RULE12
      (gate_on && !sample.valid) |=> $stable({phase3_inrush_flag, phase2_inrush_flag,
                                              phase1_inrush_flag}))
      else $error("flags changed without a sample");

   bus_answer_a: assert property (
      (req && avs_waitrequest) |=> !avs_waitrequest ##1 avs_waitrequest)
      else $error("waitrequest not low for exactly one cycle");

   ratio_flag2_a: assert property (                             // see RULE1
      (gate_on && sample.valid && (chk_harm2 <= chk_fund2)) |=> !phase2_inrush_flag)
      else $error("phase 2 flag set without harmonic ratio exceeded");

   ratio_flag3_a: assert property (                             // see RULE1
      (gate_on && sample.valid && (chk_harm3 <= chk_fund3)) |=> !phase3_inrush_flag)
      else $error("phase 3 flag set without harmonic ratio exceeded");

   min_level1_a: assert property (                              // see RULE2
      (gate_on && sample.valid && (chk_lvl1 <= chk_ref2)) |=> !phase1_inrush_flag)
      else $error("phase 1 flag set with fundamental below minimum level");

   min_level3_a: assert property (                              // see RULE8
      (gate_on && sample.valid && (chk_lvl3 <= chk_ref2)) |=> !phase3_inrush_flag)
      else $error("phase 3 flag set with fundamental below minimum level");

   ratio_write_a: assert property (                             // see RULE6
      (wr_take && (avs_address == `INR_OFS_RATIO) && (avs_writedata >= 32'(`INR_RATIO_MIN)) &&
       (avs_writedata <= 32'(`INR_RATIO_MAX))) |=> (st_q.ratio == $past(avs_writedata[6:0])))
      else $error("valid harmonic ratio write not taken");

   ratio_keep_a: assert property (                              // see RULE6
      !(wr_take && (avs_address == `INR_OFS_RATIO)) |=> $stable(st_q.ratio))
      else $error("harmonic ratio changed without a write");

   minlvl_write_a: assert property (                            // see RULE7
      (wr_take && (avs_address == `INR_OFS_MINLVL) && (avs_writedata >= 32'(`INR_MINLVL_MIN)) &&
       (avs_writedata <= 32'(`INR_MINLVL_MAX))) |=> (st_q.minlvl == $past(avs_writedata[6:0])))
      else $error("valid minimum level write not taken");

   minlvl_keep_a: assert property (                             // see RULE7
      !(wr_take && (avs_address == `INR_OFS_MINLVL)) |=> $stable(st_q.minlvl))
      else $error("minimum level changed without a write");

   enable_write_a: assert property (                            // see RULE11
      (wr_take && (avs_address == `INR_OFS_CTRL)) |=> (st_q.enable == $past(avs_writedata[0])))
      else $error("enable write not taken");

   reset_ratio_a: assert property (                             // see RULE6
      $rose(rstn) |-> (st_q.ratio == `INR_RATIO_RST))
      else $error("harmonic ratio not at its reset value");

   reset_minlvl_a: assert property (                            // see RULE7
      $rose(rstn) |-> (st_q.minlvl == `INR_MINLVL_RST))
      else $error("minimum level not at its reset value");

   reset_enable_a: assert property (                            // see RULE11
      $rose(rstn) |-> !st_q.enable && (st_q.mask == `INR_IRQ_MASK_RST))
      else $error("enable or mask not at reset value");

   gate_clear_a: assert property (                              // see RULE11
      !gate_on |=> !general_inrush_flag && !phase1_inrush_flag &&
                   !phase2_inrush_flag && !phase3_inrush_flag)
      else $error("flags not cleared while detector gated off");

   event_match_a: assert property (                             // see RULE10
      restraint_event_valid |-> (restraint_event_value == general_inrush_flag) &&
                                (general_inrush_flag != $past(general_inrush_flag)))
      else $error("event does not match a change of the general flag");

   rdata_idle_a: assert property (
      avs_waitrequest |-> (avs_readdata == 32'h0))
      else $error("read data not zero outside the answer cycle");

   rdata_unmapped_a: assert property (
      (rd_take && (avs_address > `INR_OFS_IRQ_MASK)) |-> (avs_readdata == 32'h0))
      else $error("unmapped address does not read zero");

   wait_idle_a: assert property (
      !req |=> avs_waitrequest)
      else $error("waitrequest low without a request");

   irq_cause_a: assert property (
      irq |-> (irq_status != 2'h0))
      else $error("interrupt without a status bit");

   stat_clear_a: assert property (
      (stat_rd && (irq_set == 2'h0)) |=> (irq_status == 2'h0))
      else $error("status not cleared by its read");

   stat_set_a: assert property (
      (irq_set != 2'h0) |=> ((irq_status & $past(irq_set)) == $past(irq_set)))
      else $error("event did not set its status bit");

endmodule : inr_detector

// *** verification/inr_meas_stage.sv ***
// Model of the measurement stage feeding per-phase magnitudes with a one-cycle strobe.
// Assumes the detector samples the strobe on the rising edge of mclk.
module inr_meas_stage (
   input  wire logic            mclk,    // System clock
   output inr_pkg::inr_sample_s sample   // Magnitudes with strobe
);
   timeunit 1ns;
   timeprecision 1ps;
   import inr_pkg::*;

   initial sample = '0;

   // After each strobe the magnitudes are inverted so stale values never pass for data
   task automatic send(input inr_mag_t f1, h1, f2, h2, f3, h3);
      @(posedge mclk);
      sample <= {1'b1, f3, f2, f1, h3, h2, h1};
      @(posedge mclk);
      sample <= {1'b0, ~f3, ~f2, ~f1, ~h3, ~h2, ~h1};
   endtask : send
endmodule : inr_meas_stage

// *** verification/inr_detector_tb.sv ***
// Self-checking bench for the inrush detector: Avalon-MM register tasks and sample stimulus.
// Assumes the design files and the measurement stage model are compiled first.
`include "inr_regs.svh"
module inr_detector_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import inr_pkg::*;

   logic        mclk;
   logic        rstn;
   logic [4:0]  avs_address;
   logic        avs_read;
   logic        avs_write;
   logic [31:0] avs_writedata;
   logic [31:0] avs_readdata;
   logic        avs_waitrequest;
   inr_sample_s sample;
   logic        blk;
   logic [3:0]  flg;
   logic        ev_valid;
   logic        ev_value;
   logic        irq;
   logic [31:0] rd;
   int          n_mismatch;
   int          comparisons;
   logic [31:0] wd [8] = '{32'h4, 32'h33, 32'h32, 32'h5, 32'h13, 32'h65, 32'h64, 32'h10014};
   logic [31:0] ex [8] = '{32'hf, 32'hf, 32'h32, 32'h5, 32'h1e, 32'h1e, 32'h64, 32'h64};

   inr_meas_stage meas (.mclk(mclk), .sample(sample));

   inr_detector dut (
      .mclk(mclk), .rstn(rstn), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .sample(sample), .detector_block_input(blk),
      .phase1_inrush_flag(flg[0]), .phase2_inrush_flag(flg[1]), .phase3_inrush_flag(flg[2]),
      .general_inrush_flag(flg[3]), .restraint_event_valid(ev_valid),
      .restraint_event_value(ev_value), .irq(irq)
   );

   initial begin
      mclk = 1'b0;
      forever #10 mclk = ~mclk;
   end

   task automatic summarize();
      if (n_mismatch == 0 && comparisons > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : summarize

   task automatic chk(input logic [31:0] got, exp);
      comparisons++;
      if (got !== exp) begin
         n_mismatch++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // Request held until waitrequest is sampled low; read data taken at that edge
   task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
      @(posedge mclk);
      avs_address   <= a;
      avs_writedata <= d;
      avs_write     <= wr;
      avs_read      <= !wr;
      do @(posedge mclk); while (avs_waitrequest !== 1'b0);
      rd = avs_readdata;
      avs_write <= 1'b0;
      avs_read  <= 1'b0;
   endtask : bus

   task automatic wreg(input logic [4:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask : wreg

   task automatic rreg(input logic [4:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk(rd, e);
   endtask : rreg

   task automatic fchk(input logic [3:0] e);
      #1 chk({28'h0, flg}, {28'h0, e});
   endtask : fchk

   initial begin
      #200us;
      n_mismatch++;
      summarize();
   end

   initial begin
      rstn = 1'b0;
      avs_address = 5'h00;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h0;
      blk = 1'b0;
      n_mismatch = 0;
      comparisons = 0;
      repeat (6) @(posedge mclk);
      rstn <= 1'b1;
      rreg(`INR_OFS_CTRL, 32'h0);
      rreg(`INR_OFS_RATIO, 32'h0f);
      rreg(`INR_OFS_MINLVL, 32'h1e);
      rreg(`INR_OFS_IRQ_MASK, 32'h0);
      rreg(5'h18, 32'h0);
      meas.send(16'h1000, 16'h0800, 16'h1000, 16'h0800, 16'h1000, 16'h0800);
      fchk(4'h0);
      for (int i = 0; i < 8; i++) begin
         wreg(i < 4 ? `INR_OFS_RATIO : `INR_OFS_MINLVL, wd[i]);
         rreg(i < 4 ? `INR_OFS_RATIO : `INR_OFS_MINLVL, ex[i]);
      end
      wreg(`INR_OFS_RATIO, 32'h0f);
      wreg(`INR_OFS_MINLVL, 32'h19);
      wreg(`INR_OFS_IRQ_MASK, 32'h3);
      wreg(`INR_OFS_CTRL, 32'h1);
      // Exact ratio boundary is not inrush: 0xf0 * 100 equals 0x640 * 15
      meas.send(16'h0640, 16'h00f0, 16'h0, 16'h0, 16'h0, 16'h0);
      fchk(4'h0);
      meas.send(16'h0640, 16'h00f1, 16'h0, 16'h0, 16'h0, 16'h0);
      fchk(4'h9);
      chk({ev_valid, ev_value}, 2'b11);
      // Fundamental exactly at 25 percent of nominal is too small
      meas.send(16'h0, 16'h0, 16'h0400, 16'h0200, 16'h0, 16'h0);
      fchk(4'h0);
      chk({ev_valid, ev_value}, 2'b10);
      meas.send(16'h0, 16'h0, 16'h0401, 16'h0200, 16'h0, 16'h0);
      fchk(4'ha);
      meas.send(16'h0, 16'h0, 16'h0, 16'h0, 16'h0401, 16'h0200);
      fchk(4'hc);
      rreg(`INR_OFS_FLAGS, 32'hc);
      repeat (3) @(posedge mclk);
      chk(irq, 1'b1);
      rreg(`INR_OFS_IRQ_STAT, 32'h3);
      repeat (3) @(posedge mclk);
      chk(irq, 1'b0);
      @(posedge mclk);
      blk <= 1'b1;
      @(posedge mclk);
      fchk(4'h0);
      chk({ev_valid, ev_value}, 2'b10);
      meas.send(16'h1000, 16'h0800, 16'h1000, 16'h0800, 16'h1000, 16'h0800);
      fchk(4'h0);
      @(posedge mclk);
      blk <= 1'b0;
      wreg(`INR_OFS_IRQ_MASK, 32'h0);
      rreg(`INR_OFS_IRQ_STAT, 32'h2);
      meas.send(16'h1000, 16'h0800, 16'h1000, 16'h0800, 16'h1000, 16'h0800);
      fchk(4'hf);
      repeat (3) @(posedge mclk);
      chk(irq, 1'b0);
      rreg(`INR_OFS_IRQ_STAT, 32'h1);
      // Disabling drops the flags silently, with no off event
      wreg(`INR_OFS_CTRL, 32'h0);
      repeat (2) @(posedge mclk);
      fchk(4'h0);
      repeat (2) @(posedge mclk);
      rreg(`INR_OFS_IRQ_STAT, 32'h0);
      summarize();
   end
endmodule : inr_detector_tb
